/* File: core/fsq_core.sv */
// Purpose : Frequency scan sequencer with serial programming port
// Assumes : mclk at 100 MHz; sclk unrelated, may stop between frames
// Notes   : Output sample is the top of the phase, midscale when idle
//
// Notes on behaviour
// (RQ1) Scan defined by start, step, count
// (RQ2) Auto mode times steps in clocks/cycles
// (RQ3) Auto mode: one trigger runs whole scan
// (RQ4) External mode: edges start, then step
// (RQ5) Phase never reset at a step
// (RQ6) Final frequency is start plus count times step
// (RQ7) Final frequency held until reset
// (RQ8) Auto scan lasts count plus one intervals
// (RQ9) Serial words are sixteen bits
// (RQ10) Shift only while frame select low
// (RQ11) One bit per falling serial edge
// (RQ12) Each sixteen edges form one word
// (RQ13) Host raises frame after last edge
// (RQ14) Serial clock ignored while frame high
// (RQ15) Host programs all registers after reset
// (RQ16) Host writes control register first
// (RQ17) Control write resets scan, midscale output
// (RQ18) Midscale until trigger starts scan
// (RQ19) Interrupt rising edge resets scan
// (RQ20) Address first, then data msb first
// (RQ21) Top four bits select register
// (RQ22) Paired mode commits both halves together
// (RQ23) Accumulator adds frequency every clock
// (RQ24) Serial words synchronised into master domain
`timescale 1ns/1ps
`default_nettype none
module fsq_core
    import fsq_pkg::*;
#(
    parameter int CNT_BITS = 12
)(
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  sclk,
    input  wire logic                  frame_select_n,
    input  wire logic                  serial_data_in,
    input  wire logic                  scan_trigger,
    input  wire logic                  interrupt_in,
    output var  logic [FREQ_BITS-1:0]  freq_word_r,
    output var  logic [FREQ_BITS-1:0]  phase_r,
    output var  logic [FIELD_BITS-1:0] out_sample_r,
    output var  logic                  scan_active_r,
    output var  logic                  scan_done_r
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [WORD_BITS-1:0]  rx_word;
    logic                  rx_tog;
    logic [2:0]            sync_q;
    logic                  tog_seen_r;
    logic                  trig_last_r;
    logic                  irq_last_r;
    logic                  word_ev;
    logic                  trig_rise;
    logic                  irq_rise;
    logic [WORD_BITS-1:0]  cmd_r;
    logic                  cmd_ev_r;
    logic [3:0]            cmd_addr;
    logic [11:0]           cmd_data;
    logic                  ctrl_wr;
    logic                  abort;
    logic [11:0]           ctrl_r;
    logic [CNT_BITS-1:0]   incr_count_r;
    logic [CNT_BITS-1:0]   tint_r;
    logic                  tint_cycles_r;
    logic [FREQ_BITS-1:0]  start_r;
    logic [FREQ_BITS-1:0]  delta_r;
    logic [11:0]           start_lo_pend_r;
    logic [11:0]           delta_lo_pend_r;
    fsq_state_type         state_r;
    fsq_state_type         state_nxt;
    logic [CNT_BITS-1:0]   steps_left_r;
    logic [CNT_BITS-1:0]   tick_cnt_r;
    logic [CNT_BITS-1:0]   tint_last;
    logic [FREQ_BITS:0]    phase_sum;
    logic                  paired;
    logic                  ext_mode;
    logic                  run;
    logic                  tick;
    logic                  interval_end;
    logic                  advance;
    logic                  step_ev;
    logic                  done_ev;
    logic                  start_ev;

    function automatic logic addr_is(input logic [3:0] addr, input logic [3:0] code);
        addr_is = (addr == code);
    endfunction

    // ------------------------------------------------------------
    // Serial receiver and crossings
    // ------------------------------------------------------------
    fsq_serial_rx u_rx (
        .sclk           (sclk),
        .rst_n          (rst_n),
        .frame_select_n (frame_select_n),
        .serial_data_in (serial_data_in),
        .word_r         (rx_word),
        .word_tog_r     (rx_tog)
    );

    fsq_sync2 #(.WIDTH(3)) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({rx_tog, scan_trigger, interrupt_in}),
        .sync_out (sync_q)
    );

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            tog_seen_r  <= 1'b0;
            trig_last_r <= 1'b0;
            irq_last_r  <= 1'b0;
        end
        else
        begin
            tog_seen_r  <= sync_q[2];
            trig_last_r <= sync_q[1];
            irq_last_r  <= sync_q[0];
        end
    end

    assign word_ev   = sync_q[2] ^ tog_seen_r;              // see RQ24
    assign trig_rise = sync_q[1] & ~trig_last_r;
    assign irq_rise  = sync_q[0] & ~irq_last_r;              // see RQ19

    // Word stays put: the next needs sixteen serial edges, far beyond the crossing
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cmd_r    <= '0;
            cmd_ev_r <= 1'b0;
        end
        else
        begin
            cmd_ev_r <= word_ev;
            if (word_ev)
                cmd_r <= rx_word;                            // see RQ24
        end
    end

    assign cmd_addr = cmd_r[ADDR_MSB:ADDR_LSB];             // see RQ21
    assign cmd_data = cmd_r[FIELD_BITS-1:0];
    assign ctrl_wr  = cmd_ev_r && addr_is(cmd_addr, ADDR_CTRL);
    assign abort    = ctrl_wr | irq_rise;                    // see RQ17 see RQ19
    assign paired   = ctrl_r[CTRL_PAIRED_BIT];
    assign ext_mode = ctrl_r[CTRL_EXT_BIT];

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctrl_r        <= CTRL_RST;
            incr_count_r  <= '0;
            tint_r        <= '0;
            tint_cycles_r <= 1'b0;
        end
        else if (cmd_ev_r)
        begin
            if (ctrl_wr)
                ctrl_r <= cmd_data;
            if (addr_is(cmd_addr, ADDR_INCR))
                incr_count_r <= CNT_BITS'(cmd_data);         // see RQ1
            if (cmd_addr[3:2] == ADDR_TINT_TOP)
            begin
                tint_r        <= CNT_BITS'(cmd_data);
                tint_cycles_r <= cmd_r[TINT_CYCLES_BIT];     // see RQ2
            end
        end
    end

    // Unpaired writes touch one half; paired writes commit on the high half
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            start_r         <= FREQ_RST;
            delta_r         <= FREQ_RST;
            start_lo_pend_r <= FIELD_RST;
            delta_lo_pend_r <= FIELD_RST;
        end
        else if (cmd_ev_r)
        begin
            if (addr_is(cmd_addr, ADDR_START_LO))
            begin
                start_lo_pend_r <= cmd_data;
                if (!paired)
                    start_r[11:0] <= cmd_data;
            end
            if (addr_is(cmd_addr, ADDR_START_HI))
            begin
                start_r[23:12] <= cmd_data;
                if (paired)
                    start_r[11:0] <= start_lo_pend_r;        // see RQ22
            end
            if (addr_is(cmd_addr, ADDR_DELTA_LO))
            begin
                delta_lo_pend_r <= cmd_data;
                if (!paired)
                    delta_r[11:0] <= cmd_data;
            end
            if (addr_is(cmd_addr, ADDR_DELTA_HI))
            begin
                delta_r[23:12] <= cmd_data;
                if (paired)
                    delta_r[11:0] <= delta_lo_pend_r;        // see RQ22
            end
        end
    end

    // ------------------------------------------------------------
    // Interval timing
    // ------------------------------------------------------------
    // An interval of zero is taken as one tick
    assign tint_last = (tint_r == '0) ? '0 : tint_r - CNT_BITS'(1);
    assign run       = (state_r == FSQ_RUN);
    assign phase_sum = {1'b0, phase_r} + {1'b0, freq_word_r};
    assign tick      = tint_cycles_r ? phase_sum[FREQ_BITS] : 1'b1; // see RQ2
    assign interval_end = tick && (tick_cnt_r >= tint_last);
    assign advance   = ext_mode ? trig_rise : interval_end;  // see RQ3 see RQ4
    assign start_ev  = (state_r == FSQ_IDLE) && trig_rise && !abort; // see RQ18
    assign step_ev   = run && !abort && (steps_left_r != '0) && advance;
    // External mode holds as soon as the last step is taken
    assign done_ev   = run && !abort && (steps_left_r == '0)
                       && (ext_mode || interval_end);         // see RQ8

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            tick_cnt_r <= '0;
        else if (!run || abort || step_ev)
            tick_cnt_r <= '0;
        else if (tick)
            tick_cnt_r <= tick_cnt_r + CNT_BITS'(1);         // see RQ2
    end

    // ------------------------------------------------------------
    // Scan state machine
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            FSQ_IDLE: if (start_ev) state_nxt = FSQ_RUN;
            FSQ_RUN:  if (done_ev)  state_nxt = FSQ_HOLD;
            FSQ_HOLD: state_nxt = FSQ_HOLD;                  // see RQ7
            default:  state_nxt = FSQ_IDLE;
        endcase
        if (abort)
            state_nxt = FSQ_IDLE;                            // see RQ17 see RQ19
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            state_r <= FSQ_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            freq_word_r  <= FREQ_RST;
            steps_left_r <= '0;
        end
        else if (start_ev)
        begin
            freq_word_r  <= start_r;                         // see RQ1
            steps_left_r <= incr_count_r;
        end
        else if (step_ev)
        begin
            freq_word_r  <= freq_word_r + delta_r;           // see RQ6
            steps_left_r <= steps_left_r - CNT_BITS'(1);
        end
    end

    // ------------------------------------------------------------
    // Phase accumulator and output
    // ------------------------------------------------------------
    // Phase is cleared by reset, by an abort or while idle, never by a step
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            phase_r <= FREQ_RST;
        else if (abort || state_r == FSQ_IDLE)
            phase_r <= FREQ_RST;
        else
            phase_r <= phase_sum[FREQ_BITS-1:0];             // see RQ5 see RQ23
    end
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            out_sample_r  <= MIDSCALE;
            scan_active_r <= 1'b0;
            scan_done_r   <= 1'b0;
        end
        else
        begin
            out_sample_r  <= (state_r == FSQ_IDLE) ? MIDSCALE
                             : phase_r[FREQ_BITS-1:FREQ_BITS-FIELD_BITS]; // see RQ18
            scan_active_r <= (state_nxt == FSQ_RUN);
            scan_done_r   <= (state_nxt == FSQ_HOLD);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    idle_midscale_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ18
        (state_r == FSQ_IDLE) |=> (out_sample_r == MIDSCALE))
        else $error("output not midscale while idle");

    phase_cont_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ5
        (state_r != FSQ_IDLE && !abort)
        |=> (phase_r == FREQ_BITS'($past(phase_r) + $past(freq_word_r))))
        else $error("phase not continuous");

    step_size_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ6
        step_ev |=> (freq_word_r == FREQ_BITS'($past(freq_word_r) + $past(delta_r))))
        else $error("step not by programmed size");

    start_load_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ1
        start_ev |=> (freq_word_r == $past(start_r)) && (steps_left_r == $past(incr_count_r))
                     && (state_r == FSQ_RUN))
        else $error("scan start did not load profile");

    hold_final_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ7
        (state_r == FSQ_HOLD && !abort) |=> (state_r == FSQ_HOLD) && $stable(freq_word_r))
        else $error("final frequency not held");

    ctrl_reset_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ17
        ctrl_wr |=> (state_r == FSQ_IDLE) ##1 (out_sample_r == MIDSCALE))
        else $error("control write did not reset scan");

    irq_reset_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ19
        $rose(sync_q[0]) |=> (state_r == FSQ_IDLE) && (phase_r == FREQ_RST))
        else $error("interrupt edge did not reset scan");

    ext_step_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ4
        (run && ext_mode && !trig_rise && !abort) |=> $stable(freq_word_r))
        else $error("external mode stepped without edge");

    auto_wait_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ2
        (run && !ext_mode && !interval_end && !abort)
        |=> $stable(freq_word_r) && (state_r == FSQ_RUN))
        else $error("auto step before interval end");

    paired_lo_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ22
        (cmd_ev_r && paired && addr_is(cmd_addr, ADDR_START_LO)) |=> $stable(start_r))
        else $error("paired low half changed start");

endmodule
`default_nettype wire

/* File: pkg/fsq_pkg.sv */
// Purpose : Shared constants and types of the frequency scan sequencer
// Assumes : 16-bit serial words, 24-bit frequency words, 12-bit fields
// Notes   : Address codes sit in word bits 15..12
package fsq_pkg;

    // ------------------------------------------------------------
    // Serial word layout
    // ------------------------------------------------------------
    localparam int          WORD_BITS      = 16;
    localparam int          ADDR_MSB       = 15;
    localparam int          ADDR_LSB       = 12;
    localparam int          FIELD_BITS     = 12;
    localparam int          FREQ_BITS      = 24;
    localparam logic [3:0]  BIT_CNT_LAST   = 4'hF;
    localparam logic [3:0]  BIT_CNT_RST    = 4'h0;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL      = 4'h0;
    localparam logic [3:0]  ADDR_INCR      = 4'h1;
    localparam logic [3:0]  ADDR_DELTA_LO  = 4'h2;
    localparam logic [3:0]  ADDR_DELTA_HI  = 4'h3;
    localparam logic [1:0]  ADDR_TINT_TOP  = 2'h1;
    localparam logic [3:0]  ADDR_START_LO  = 4'hC;
    localparam logic [3:0]  ADDR_START_HI  = 4'hD;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_PAIRED_BIT = 11;
    localparam int          CTRL_EXT_BIT    = 5;
    localparam int          TINT_CYCLES_BIT = 13;
    localparam logic [11:0] CTRL_RST        = 12'h000;
    localparam logic [11:0] FIELD_RST       = 12'h000;
    localparam logic [23:0] FREQ_RST        = 24'h000000;
    localparam logic [11:0] MIDSCALE        = 12'h800;

    typedef enum logic [1:0] {
        FSQ_IDLE = 2'b00,
        FSQ_RUN  = 2'b01,
        FSQ_HOLD = 2'b10
    } fsq_state_type;

endpackage

/* File: core/fsq_sync2.sv */
// Purpose : Two-flop synchroniser into the master clock domain
// Assumes : Each bit is an independent level
// Notes   : First stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module fsq_sync2
    import fsq_pkg::*;
#(
    parameter int WIDTH = 3
)(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meta_r   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule
`default_nettype wire

/* File: core/fsq_serial_rx.sv */
// Purpose : Serial word receiver on the serial clock
// Assumes : Host changes data away from the falling serial clock edge
// Notes   : Completed word is held and announced by a toggle
`timescale 1ns/1ps
`default_nettype none
module fsq_serial_rx
    import fsq_pkg::*;
(
    input  wire logic                 sclk,
    input  wire logic                 rst_n,
    input  wire logic                 frame_select_n,
    input  wire logic                 serial_data_in,
    output var  logic [WORD_BITS-1:0] word_r,
    output var  logic                 word_tog_r
);

    logic [WORD_BITS-2:0] shift_r;
    logic [3:0]           bit_cnt_r;

    // ------------------------------------------------------------
    // Bit counter
    // ------------------------------------------------------------
    // Frame high clears the count without any clock edge, since the
    // serial clock may stand still between writes
    always_ff @(negedge sclk or negedge rst_n or posedge frame_select_n)
    begin
        if (!rst_n)
            bit_cnt_r <= BIT_CNT_RST;
        else if (frame_select_n)
            bit_cnt_r <= BIT_CNT_RST;                        // see RQ10 see RQ14
        else
            bit_cnt_r <= bit_cnt_r + 4'h1;                   // see RQ12
    end

    // ------------------------------------------------------------
    // Shift and capture
    // ------------------------------------------------------------
    always_ff @(negedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_r    <= '0;
            word_r     <= '0;
            word_tog_r <= 1'b0;
        end
        else if (!frame_select_n)
        begin
            shift_r <= {shift_r[WORD_BITS-3:0], serial_data_in}; // see RQ11 see RQ20
            if (bit_cnt_r == BIT_CNT_LAST)
            begin
                word_r     <= {shift_r, serial_data_in};     // see RQ9
                word_tog_r <= ~word_tog_r;
            end
        end
    end

    word_done_a: assert property (@(negedge sclk) disable iff (!rst_n) // see RQ11
        (!frame_select_n && bit_cnt_r == BIT_CNT_LAST) |=> (word_tog_r != $past(word_tog_r)))
        else $error("word not completed on sixteenth edge");

endmodule
`default_nettype wire

/* File: verif/fsq_host_model.sv */
// Purpose : Host model driving the serial programming port
// Assumes : Serial clock of 48 ns, resting high between frames
// Notes   : Data line flips once a frame ends, since nothing samples it then
`timescale 1ns/1ps
`default_nettype none
module fsq_host_model
(
    output var logic sclk,
    output var logic frame_select_n,
    output var logic serial_data_in
);
    initial
    begin
        sclk           = 1'b1;
        frame_select_n = 1'b1;
        serial_data_in = 1'b0;
    end

    // Whole words only, several per frame allowed
    task automatic send(input logic [15:0] q[$]);
        frame_select_n = 1'b0;
        #12;
        foreach (q[i])
            for (int b = 15; b >= 0; b--)
            begin
                serial_data_in = q[i][b];
                #12 sclk = 1'b0;
                #24 sclk = 1'b1;
                #12;
            end
        frame_select_n = 1'b1;
        serial_data_in = ~serial_data_in;
        // Keeps frame high for a while so two frames never merge in one step
        #24;
    endtask
endmodule
`default_nettype wire

/* File: verif/frequency_scan_sequencer_tb.sv */
// Purpose : Self-checking bench of the frequency scan sequencer
// Assumes : Trigger and interrupt move on falling mclk edges
// Notes   : Scan figures come from a fixed-seed LFSR
`timescale 1ns/1ps
`default_nettype none
module frequency_scan_sequencer_tb
    import fsq_pkg::*;
;
    logic        mclk, rst_n, scan_trigger, interrupt_in, prun;
    logic        sclk, frame_select_n, serial_data_in;
    logic [23:0] freq_word_r, phase_r, pph, pfq, st, dl;
    logic [11:0] out_sample_r, n, ti;
    logic        scan_active_r, scan_done_r;
    logic [31:0] seed;
    int          err_total, tests_run, run_len;

    fsq_host_model host (.sclk(sclk), .frame_select_n(frame_select_n),
                         .serial_data_in(serial_data_in));
    fsq_core #(.CNT_BITS(12)) dut (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
        .frame_select_n(frame_select_n), .serial_data_in(serial_data_in),
        .scan_trigger(scan_trigger), .interrupt_in(interrupt_in),
        .freq_word_r(freq_word_r), .phase_r(phase_r), .out_sample_r(out_sample_r),
        .scan_active_r(scan_active_r), .scan_done_r(scan_done_r));

    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        scan_trigger = 1'b0;
        interrupt_in = 1'b0;
        prun = 1'b0;
        err_total = 0;
        tests_run = 0;
        run_len = 0;
        seed = 32'h6E73B5DC;
    end
    always #5 mclk = ~mclk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [23:0] nx();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[23:0];
    endfunction
    function automatic logic [23:0] fin(input logic [23:0] s, d, input logic [11:0] k);
        return s + d * k;
    endfunction
    task automatic chk(input string nm, input logic [23:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic wr(input logic [15:0] w);
        host.send('{w});
        cyc(8);
    endtask
    task automatic waitf(input logic done_sel);
        int i;
        for (i = 0; i < 5000; i++)
        begin
            if ((done_sel ? scan_done_r : scan_active_r) === 1'b1)
                break;
            cyc(1);
        end
        if (i == 5000)
        begin
            err_total++;
            $display("MISMATCH wait expected 1 seen timeout");
            conclude();
        end
    endtask
    task automatic trig();
        scan_trigger = 1'b1;
        cyc(3);
        scan_trigger = 1'b0;
        cyc(3);
    endtask

    // ------------------------------------------------------------
    // Continuous phase and output monitor
    // ------------------------------------------------------------
    always @(negedge mclk)
    begin
        if (rst_n && prun && (scan_active_r || scan_done_r))
        begin
            chk("phase", phase_r, pph + pfq);
            chk("sample", 24'(out_sample_r), 24'(pph[23:12]));
        end
        if (rst_n && !prun && !scan_active_r && !scan_done_r)
            chk("idle_sample", 24'(out_sample_r), 24'(MIDSCALE));
        run_len = (scan_active_r || scan_done_r) ? run_len + int'(scan_active_r) : 0;
        prun = scan_active_r || scan_done_r;
        pph = phase_r;
        pfq = freq_word_r;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        cyc(6);
        rst_n = 1'b1;
        cyc(2);
        for (int k = 0; k < 4; k++)
        begin
            st = nx();
            dl = nx();
            n = 12'(nx() % 4) + 12'h001;
            ti = 12'(nx() % (k[0] ? 3 : 8)) + 12'h001;
            // Cycle-paced runs keep every frequency high so an interval stays short
            if (k[0])
            begin
                st[23:22] = 2'b01;
                dl[23:20] = 4'h0;
            end
            wr({ADDR_CTRL, 12'h800});
            chk("ctrl_reset", 24'({scan_active_r, scan_done_r}), 24'h000000);
            wr({ADDR_INCR, n});
            host.send('{{ADDR_DELTA_LO, dl[11:0]}, {ADDR_DELTA_HI, dl[23:12]}});
            host.send('{{ADDR_START_LO, st[11:0]}, {ADDR_START_HI, st[23:12]}});
            wr({ADDR_TINT_TOP, k[0], 1'b0, ti});
            scan_trigger = 1'b1;
            waitf(1'b0);
            chk("start_freq", freq_word_r, st);
            cyc(1);
            scan_trigger = 1'b0;
            cyc(2);
            waitf(1'b1);
            chk("final_freq", freq_word_r, fin(st, dl, n));
            if (!k[0])
                chk("scan_len", 24'(run_len), 24'((n + 12'h001) * ti));
            trig();
            cyc(20);
            chk("hold_freq", freq_word_r, fin(st, dl, n));
        end
        $display("Test auto_scan done");
        wr({ADDR_CTRL, 12'h820});
        wr({ADDR_INCR, 12'h002});
        host.send('{{ADDR_START_LO, ~st[11:0]}, {4'hE, 12'hFFF}, {4'hA, 12'h5A5}});
        cyc(8);
        trig();
        chk("ext_start", freq_word_r, st);
        for (int i = 1; i <= 2; i++)
        begin
            trig();
            chk("ext_step", freq_word_r, fin(st, dl, 12'(i)));
        end
        chk("ext_done", 24'(scan_done_r), 24'h000001);
        trig();
        chk("ext_hold", freq_word_r, fin(st, dl, 12'h002));
        $display("Test ext_scan done");
        wr({ADDR_START_HI, st[23:12]});
        interrupt_in = 1'b1;
        cyc(8);
        chk("irq_idle", 24'({scan_active_r, scan_done_r}), 24'h000000);
        chk("irq_sample", 24'(out_sample_r), 24'(MIDSCALE));
        interrupt_in = 1'b0;
        cyc(2);
        trig();
        chk("paired_commit", freq_word_r, {st[23:12], ~st[11:0]});
        $display("Test interrupt done");
        wr({ADDR_CTRL, 12'h000});
        host.send('{{ADDR_START_LO, dl[11:0]}, {ADDR_TINT_TOP, 2'b00, 12'h0C8}});
        cyc(8);
        trig();
        chk("unpaired_lo", freq_word_r, {st[23:12], dl[11:0]});
        chk("long_run", 24'(scan_active_r), 24'h000001);
        wr({ADDR_CTRL, 12'h000});
        chk("wr_idle", 24'({scan_active_r, scan_done_r}), 24'h000000);
        chk("wr_sample", 24'(out_sample_r), 24'(MIDSCALE));
        $display("Test ctrl_abort done");
        conclude();
    end
endmodule
`default_nettype wire
